/* File: src/cwe_map.svh */
// Register offsets, field positions, reset values and cycle-length counts of the window enable block
`ifndef CWE_MAP_SVH
`define CWE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte offsets on the register port)
// ----------------------------------------------------------------
`define CWE_OFS_WIN_ENABLE 8'h06
`define CWE_OFS_IO_CTL 8'h07
`define CWE_OFS_IO_ADDR_FIRST 8'h08
`define CWE_OFS_IO_ADDR_LAST 8'h0f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CWE_BIT_IO1_ON 7
`define CWE_BIT_IO0_ON 6
`define CWE_BIT_RSVD 5
`define CWE_MEM_ON_MSB 4
`define CWE_IO1_CTL_LSB 4
`define CWE_IO0_CTL_LSB 0

// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define CWE_RST_WIN_ENABLE 8'h00
`define CWE_RST_IO_CTL 8'h00
`define CWE_RST_IO_ADDR 8'h00
`define CWE_WMASK_WIN_ENABLE 8'hdf

// ----------------------------------------------------------------
// Card I/O cycle lengths in ISA-equivalent cycles
// ----------------------------------------------------------------
`define CWE_LEN16_STD 4'h3
`define CWE_LEN16_WAIT 4'h4
`define CWE_LEN8_STD 4'h6
`define CWE_LEN8_SHORT 4'h3

`endif

/* File: src/cwe_pkg.sv */
// Types shared by the window enable block
package cwe_pkg;

   // Per-window I/O cycle control nibble, msb first as in the register
   typedef struct packed
   {
      logic extra_wait;
      logic short_cycle;
      logic auto_width;
      logic width_sel;
   } cwe_io_ctl_t;

   typedef logic [7:0] cwe_byte_t;
   typedef logic [15:0] cwe_addr_t;
   typedef logic [3:0] cwe_len_t;

endpackage

/* File: src/cwe_win_if.sv */
// Carrier between the register bank and the I/O window decoder
`timescale 1ns/100ps
interface cwe_win_if;
   logic [1:0] io_on;
   cwe_pkg::cwe_io_ctl_t ctl [2];
   cwe_pkg::cwe_addr_t start [2];
   cwe_pkg::cwe_addr_t stop [2];
   cwe_pkg::cwe_addr_t addr;
   logic iois16;
   logic [1:0] hit;
   logic width16;
   cwe_pkg::cwe_len_t len;

   modport cfg (output io_on, ctl, start, stop, addr, iois16, input hit, width16, len);
   modport dec (input io_on, ctl, start, stop, addr, iois16, output hit, width16, len);
endinterface

/* File: src/cwe_io_decode.sv */
// Address compare, width choice and cycle length for the two I/O windows
`timescale 1ns/100ps
`include "cwe_map.svh"
module cwe_io_decode
(
   cwe_win_if.dec win // Window settings in, decode out
);

   wire [1:0] in_range;
   wire [1:0] w16;
   cwe_pkg::cwe_len_t len_w [2];

   // ----------------------------------------------------------------
   // Per-window decode
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_win
         // Inclusive bounds; a window with start above end never claims
         assign in_range[i] = (win.addr >= win.start[i]) && (win.addr <= win.stop[i]);
         // Enable gates the compare whatever the bounds hold
         assign win.hit[i] = win.io_on[i] & in_range[i];
         // Card sizing overrides the size bit
         assign w16[i] = win.ctl[i].auto_width ? win.iois16 : win.ctl[i].width_sel;
         // Wait bit touches only wide cycles, short bit only narrow ones
         assign len_w[i] = w16[i] ?
            (win.ctl[i].extra_wait ? `CWE_LEN16_WAIT : `CWE_LEN16_STD) :
            (win.ctl[i].short_cycle ? `CWE_LEN8_SHORT : `CWE_LEN8_STD);
      end
   endgenerate

   // Window 0 wins when both windows overlap
   wire sel1 = win.hit[1] & ~win.hit[0];
   assign win.width16 = sel1 ? w16[1] : w16[0];
   assign win.len = sel1 ? len_w[1] : len_w[0];

endmodule

/* File: src/cwe_window_enable.sv */
// Window enable and I/O window control registers with host cycle claim logic
`timescale 1ns/100ps
`include "cwe_map.svh"
// Functional notes
// - Reset leaves all windows disabled and the enable register at zero.
// - A window with its enable bit clear never claims a host cycle.
// - Enable bit 7 turns on I/O window 1, bit 6 I/O window 0.
// - Enable bits 4 to 0 turn on memory windows 4 to 0.
// - Enable bit 5 ignores writes and reads zero.
// - Extra-wait bit lengthens wide I/O cycles by one wait state only.
// - Short-cycle bit cuts narrow I/O cycles to three cycles only.
// - Auto-width bit takes transfer width from the card's sizing pin.
// - Without auto-width, size bit picks 8-bit (0) or 16-bit (1).
// - I/O control register resets to zero: narrow, standard, no auto sizing.
// - Each I/O window holds 16-bit start and end as byte registers.
module cwe_window_enable
(
   input wire logic core_clk_in, // Bus clock, 10 MHz
   input wire logic rst_n_in, // Asynchronous reset, active low
   input wire logic reg_wr_in, // Register write strobe
   input wire logic reg_rd_in, // Register read strobe
   input wire logic [7:0] reg_addr_in, // Register byte offset
   input wire logic [7:0] reg_wdata_in, // Register write data
   output logic [7:0] reg_rdata_out, // Register read data, held after a read
   input wire logic mem_cycle_in, // Host memory cycle toward the card
   input wire logic [4:0] mem_hit_in, // Memory window address matches
   output logic [4:0] mem_claim_out, // Memory windows claiming the cycle
   input wire logic io_cycle_in, // Host I/O cycle toward the card
   input wire logic [15:0] io_addr_in, // Host I/O address
   input wire logic iois16_in, // Card reports a 16-bit port
   output logic [1:0] io_claim_out, // I/O windows claiming the cycle
   output logic io_width16_out, // Claimed cycle is 16 bits wide
   output logic [3:0] io_cycle_len_out // Claimed cycle length in ISA cycles
);

   cwe_win_if win ();

   cwe_pkg::cwe_byte_t win_enable;
   cwe_pkg::cwe_byte_t io_ctl;
   cwe_pkg::cwe_byte_t io_addr_byte [8];

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire hit_enable = (reg_addr_in == `CWE_OFS_WIN_ENABLE);
   wire hit_ctl = (reg_addr_in == `CWE_OFS_IO_CTL);
   wire hit_addr = (reg_addr_in >= `CWE_OFS_IO_ADDR_FIRST) && (reg_addr_in <= `CWE_OFS_IO_ADDR_LAST);
   wire [2:0] addr_idx = reg_addr_in[2:0];
   wire wr_enable = reg_wr_in & hit_enable;
   wire wr_ctl = reg_wr_in & hit_ctl;
   wire wr_addr = reg_wr_in & hit_addr;
   // Reserved bit is masked off so it can never be set
   wire [7:0] next_win_enable = reg_wdata_in & `CWE_WMASK_WIN_ENABLE;
   // Unmapped offsets read as zero
   wire [7:0] rd_mux = hit_enable ? win_enable :
                       hit_ctl ? io_ctl :
                       hit_addr ? io_addr_byte[addr_idx] : 8'h00;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Both registers clear on reset so no window is live before software sets it up
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         win_enable <= `CWE_RST_WIN_ENABLE;
         io_ctl <= `CWE_RST_IO_CTL;
      end
      else
      begin
         if (wr_enable)
            win_enable <= next_win_enable;
         if (wr_ctl)
            io_ctl <= reg_wdata_in;
      end
   end

   // Start and end bytes: 08..0b window 0, 0c..0f window 1
   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1)
      begin : g_addr
         always_ff @(posedge core_clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
               io_addr_byte[b] <= `CWE_RST_IO_ADDR;
            else if (wr_addr && (addr_idx == 3'(b)))
               io_addr_byte[b] <= reg_wdata_in;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Decoder hookup
   // ----------------------------------------------------------------
   assign win.io_on = {win_enable[`CWE_BIT_IO1_ON], win_enable[`CWE_BIT_IO0_ON]};
   assign win.ctl[0] = io_ctl[`CWE_IO0_CTL_LSB +: 4];
   assign win.ctl[1] = io_ctl[`CWE_IO1_CTL_LSB +: 4];
   assign win.start[0] = {io_addr_byte[1], io_addr_byte[0]};
   assign win.stop[0] = {io_addr_byte[3], io_addr_byte[2]};
   assign win.start[1] = {io_addr_byte[5], io_addr_byte[4]};
   assign win.stop[1] = {io_addr_byte[7], io_addr_byte[6]};
   assign win.addr = io_addr_in;
   assign win.iois16 = iois16_in;

   cwe_io_decode u_dec
   (
      .win (win)
   );

   // Memory window gate; address match comes from the memory window compare outside
   wire [4:0] mem_gate = mem_hit_in & win_enable[`CWE_MEM_ON_MSB:0];

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // One cycle from host cycle to claim; claims drop outside a cycle
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mem_claim_out <= 5'h00;
         io_claim_out <= 2'h0;
         io_width16_out <= 1'b0;
         io_cycle_len_out <= 4'h0;
         reg_rdata_out <= 8'h00;
      end
      else
      begin
         mem_claim_out <= mem_cycle_in ? mem_gate : 5'h00;
         io_claim_out <= io_cycle_in ? win.hit : 2'h0;
         io_width16_out <= io_cycle_in & (|win.hit) & win.width16;
         io_cycle_len_out <= (io_cycle_in && (|win.hit)) ? win.len : 4'h0;
         if (reg_rd_in)
            reg_rdata_out <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Bound snapshots so the range checks can take their past values
   cwe_pkg::cwe_addr_t start0;
   cwe_pkg::cwe_addr_t stop0;
   cwe_pkg::cwe_addr_t start1;
   cwe_pkg::cwe_addr_t stop1;
   assign start0 = win.start[0];
   assign stop0 = win.stop[0];
   assign start1 = win.start[1];
   assign stop1 = win.stop[1];

   // Gating, register and window 0 checks
   a_mem_gate_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (mem_claim_out & ~$past(win_enable[4:0])) == 5'h00) else $error("Memory window claimed while disabled");
   a_io_gate_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      io_claim_out[1] |-> $past(win_enable[`CWE_BIT_IO1_ON])) else $error("I/O window 1 claimed while disabled");
   a_rsvd_bit_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit_enable |=> reg_rdata_out[`CWE_BIT_RSVD] == 1'b0) else $error("Reserved bit read as one");
   a_enable_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wr_enable |=> win_enable == ($past(reg_wdata_in) & 8'hdf)) else $error("Enable register write lost");
   a_ctl_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wr_ctl |=> io_ctl == $past(reg_wdata_in)) else $error("Control register write lost");
   a_wide_wait_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h1) && io_width16_out |-> io_cycle_len_out == ($past(io_ctl[3]) ? 4'h4 : 4'h3))
      else $error("Wide cycle length wrong");
   a_short_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h1) && !io_width16_out |-> io_cycle_len_out == ($past(io_ctl[2]) ? 4'h3 : 4'h6))
      else $error("Narrow cycle length wrong");
   a_auto_width: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h1) && $past(io_ctl[1]) |-> io_width16_out == $past(iois16_in)) else $error("Auto width ignored");
   a_size_select: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h1) && !$past(io_ctl[1]) |-> io_width16_out == $past(io_ctl[0])) else $error("Size bit ignored");
   a_range_inside: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      io_claim_out[0] |-> ($past(io_addr_in) >= $past(start0)) && ($past(io_addr_in) <= $past(stop0)))
      else $error("Claim outside window 0 range");
   a_start_readback: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_wr_in && (reg_addr_in == 8'h08) ##1 !(reg_wr_in && (reg_addr_in == 8'h08))
      ##1 reg_rd_in && (reg_addr_in == 8'h08) |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("Start byte readback wrong");

   // Claims and lengths exist only while the host runs a cycle; stale values would steer the card
   a_io_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !$past(io_cycle_in) |-> (io_claim_out == 2'h0) && (io_cycle_len_out == 4'h0) && !io_width16_out)
      else $error("I/O claim without a host cycle");
   a_mem_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !$past(mem_cycle_in) |-> mem_claim_out == 5'h00) else $error("Memory claim without a host cycle");
   a_no_claim_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h0) |-> (io_cycle_len_out == 4'h0) && !io_width16_out)
      else $error("Length without a claim");
   a_io0_gate_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      io_claim_out[0] |-> $past(win_enable[`CWE_BIT_IO0_ON]))
      else $error("I/O window 0 claimed while disabled");
   a_mem_claim_on: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(mem_cycle_in) |-> mem_claim_out == ($past(mem_hit_in) & $past(win_enable[`CWE_MEM_ON_MSB:0])))
      else $error("Enabled memory window did not claim");
   a_rsvd_held_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      win_enable[`CWE_BIT_RSVD] == 1'b0) else $error("Reserved enable bit set");
   a_addr_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      wr_addr |=> io_addr_byte[$past(addr_idx)] == $past(reg_wdata_in))
      else $error("Address byte write lost");

   // ----------------------------------------------------------------
   // Assertions on I/O window 1
   // ----------------------------------------------------------------
   // Window 1 owns width and length only when window 0 stays out of the cycle
   a_io1_wide_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h2) && io_width16_out |-> io_cycle_len_out == ($past(io_ctl[7]) ? 4'h4 : 4'h3))
      else $error("Window 1 wide cycle length wrong");
   a_io1_narrow_len: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h2) && !io_width16_out |-> io_cycle_len_out == ($past(io_ctl[6]) ? 4'h3 : 4'h6))
      else $error("Window 1 narrow cycle length wrong");
   a_io1_auto_width: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h2) && $past(io_ctl[5]) |-> io_width16_out == $past(iois16_in))
      else $error("Window 1 auto width ignored");
   a_io1_size_sel: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (io_claim_out == 2'h2) && !$past(io_ctl[5]) |-> io_width16_out == $past(io_ctl[4]))
      else $error("Window 1 size bit ignored");
   a_io1_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      io_claim_out[1] |-> ($past(io_addr_in) >= $past(start1)) && ($past(io_addr_in) <= $past(stop1)))
      else $error("Claim outside window 1 range");

endmodule

/* File: tb/cwe_host_model.sv */
// Host bus master model: register accesses and memory or I/O cycles toward the card
`timescale 1ns/100ps
module cwe_host_model
(
   input wire logic core_clk_in, // Bus clock
   output logic reg_wr_out, // Write strobe
   output logic reg_rd_out, // Read strobe
   output logic [7:0] reg_addr_out, // Register offset
   output logic [7:0] reg_wdata_out, // Write data
   input wire logic [7:0] reg_rdata_in, // Read data
   output logic mem_cycle_out, // Memory cycle present
   output logic [4:0] mem_hit_out, // Memory window matches
   input wire logic [4:0] mem_claim_in, // Memory claims
   output logic io_cycle_out, // I/O cycle present
   output logic [15:0] io_addr_out, // I/O address
   output logic iois16_out, // Card sizing pin
   input wire logic [1:0] io_claim_in, // I/O claims
   input wire logic io_width16_in, // Claimed width
   input wire logic [3:0] io_cycle_len_in // Claimed length
);
   // Idle values; qualifiers are inverted between requests so stale data never matches
   initial
   begin
      {reg_wr_out, reg_rd_out, mem_cycle_out, io_cycle_out, iois16_out} = 5'h00;
      {reg_addr_out, reg_wdata_out, mem_hit_out, io_addr_out} = 37'h0;
   end

   // One write, taken at the rising edge between two falling edges
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge core_clk_in);
      reg_wr_out = 1'b0;
      reg_wdata_out = ~d;
   endtask

   // One read; data is registered at the read edge and holds afterwards
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge core_clk_in);
      reg_rd_out = 1'b0;
      d = reg_rdata_in;
   endtask

   // One memory cycle; claim appears one edge later
   task automatic mem(input logic [4:0] h, output logic [4:0] c);
      @(negedge core_clk_in);
      mem_cycle_out = 1'b1;
      mem_hit_out = h;
      @(negedge core_clk_in);
      c = mem_claim_in;
      mem_cycle_out = 1'b0;
      mem_hit_out = ~h;
   endtask

   // One I/O cycle; answer packed as claim, width, length
   task automatic io(input logic [15:0] a, input logic s, output logic [7:0] r);
      @(negedge core_clk_in);
      io_cycle_out = 1'b1;
      io_addr_out = a;
      iois16_out = s;
      @(negedge core_clk_in);
      r = {1'b0, io_claim_in, io_width16_in, io_cycle_len_in};
      io_cycle_out = 1'b0;
      io_addr_out = ~a;
      iois16_out = ~s;
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the window enable block
`timescale 1ns/100ps
`include "cwe_map.svh"
module testbench;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic reg_wr, reg_rd, mem_cycle, io_cycle, iois16, width16;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
   logic [4:0] mem_hit, mem_claim, mc;
   logic [15:0] io_addr;
   logic [1:0] io_claim;
   logic [3:0] cyc_len, c;
   logic ew;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] cfg [8] = '{8'h00, 8'h12, 8'hff, 8'h12, 8'h00, 8'h34, 8'h10, 8'h34};
   logic [15:0] pa [8] = '{16'h1200, 16'h12ff, 16'h11ff, 16'h1300, 16'h3400, 16'h3410, 16'h3411, 16'h33ff};
   logic [1:0] pc [8] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0};

   always #50 core_clk_in = ~core_clk_in;

   cwe_window_enable uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
      .mem_cycle_in(mem_cycle), .mem_hit_in(mem_hit), .mem_claim_out(mem_claim), .io_cycle_in(io_cycle),
      .io_addr_in(io_addr), .iois16_in(iois16), .io_claim_out(io_claim), .io_width16_out(width16),
      .io_cycle_len_out(cyc_len));

   cwe_host_model host (.core_clk_in(core_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
      .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata),
      .mem_cycle_out(mem_cycle), .mem_hit_out(mem_hit), .mem_claim_in(mem_claim), .io_cycle_out(io_cycle),
      .io_addr_out(io_addr), .iois16_out(iois16), .io_claim_in(io_claim), .io_width16_in(width16),
      .io_cycle_len_in(cyc_len));

   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge core_clk_in);
      @(negedge core_clk_in) rst_n_in = 1'b1;
      host.rd(8'h06, d);
      chk(d, 8'h00, "enable at reset");
      host.rd(8'h07, d);
      chk(d, 8'h00, "control at reset");
      host.rd(8'h20, d);
      chk(d, 8'h00, "unmapped read");
      host.mem(5'h1f, mc);
      chk({3'h0, mc}, 8'h00, "memory claim while disabled");
      host.wr(8'h06, 8'hff);
      host.rd(8'h06, d);
      chk(d, 8'hdf, "reserved bit");
      host.mem(5'h0a, mc);
      chk({3'h0, mc}, 8'h0a, "memory claim needs match");
      // One memory window at a time
      for (int i = 0; i < 5; i++)
      begin
         host.wr(8'h06, 8'h01 << i);
         host.mem(5'h1f, mc);
         chk({3'h0, mc}, 8'h01 << i, "memory window enable");
      end
      host.wr(8'h08, 8'h5a);
      host.rd(8'h08, d);
      chk(d, 8'h5a, "start low byte readback");
      // Window 0 covers 1200..12ff, window 1 covers 3400..3410
      for (int k = 0; k < 8; k++)
         host.wr(8'(8'h08 + k), cfg[k]);
      host.rd(8'h0b, d);
      chk(d, 8'h12, "end high byte");
      host.wr(8'h06, 8'hc0);
      for (int k = 0; k < 8; k++)
      begin
         host.io(pa[k], 1'b0, r);
         chk(r, {1'b0, pc[k], 1'b0, (pc[k] != 2'h0) ? `CWE_LEN8_STD : 4'h0}, "range claim");
      end
      host.wr(8'h06, 8'h80);
      host.io(16'h1234, 1'b1, r);
      chk(r, 8'h00, "io window 0 off");
      host.io(16'h3405, 1'b0, r);
      chk(r, {3'h2, 1'b0, `CWE_LEN8_STD}, "io window 1 on");
      // Every control nibble on each window, with both sizing pin levels
      host.wr(8'h06, 8'hc0);
      for (int w = 0; w < 2; w++)
         for (int n = 0; n < 16; n++)
            for (int s = 0; s < 2; s++)
            begin
               c = 4'(n);
               ew = c[1] ? s[0] : c[0];
               host.wr(8'h07, w ? {c, 4'h0} : {4'h0, c});
               host.io(w ? 16'h3408 : 16'h1280, s[0], r);
               chk(r, {1'b0, w ? 2'h2 : 2'h1, ew, ew ? (c[3] ? `CWE_LEN16_WAIT : `CWE_LEN16_STD)
                  : (c[2] ? `CWE_LEN8_SHORT : `CWE_LEN8_STD)}, "width and length");
            end
      host.rd(8'h07, d);
      chk(d, 8'hf0, "control readback");
      // Reset in mid-run clears both registers
      @(negedge core_clk_in) rst_n_in = 1'b0;
      @(negedge core_clk_in) rst_n_in = 1'b1;
      host.rd(8'h06, d);
      chk(d, 8'h00, "enable after second reset");
      host.rd(8'h07, d);
      chk(d, 8'h00, "control after second reset");
      tally_and_finish();
   end

   // Watchdog; the sequence needs well under 1000 cycles
   initial
   begin
      #300000;
      fail_count++;
      tally_and_finish();
   end
endmodule
